/* File: verilog/nfe_pkg.sv */
// Register map, field layout and state codes of the NAND flash check-value block
// How it works
// - 8-bit flash: P1-P4 columns, P8-P2048 rows
// - 16-bit flash: P1-P8 columns, rest rows
// - Parity result: odd 27:16, even 11:0, read-only
// - Loaded check values feed the syndrome computation
// - Eight check values, odd low, even high
// - Four error locations in two pair registers
// - Four error values in two pair registers
// - Reading check registers clears multi-bit start
// - Reading location/value registers clears locate start
// - Reading parity result clears that select's start
// - Error count field holds errors minus one
package nfe_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_PAR1 = 8'h08;
  localparam logic [7:0] OFS_PAR4 = 8'h14;
  localparam logic [7:0] OFS_LOAD = 8'h18;
  localparam logic [7:0] OFS_CHK1 = 8'h1C;
  localparam logic [7:0] OFS_CHK4 = 8'h28;
  localparam logic [7:0] OFS_LOC1 = 8'h2C;
  localparam logic [7:0] OFS_LOC2 = 8'h30;
  localparam logic [7:0] OFS_VAL1 = 8'h34;
  localparam logic [7:0] OFS_VAL2 = 8'h38;

  // Control register fields
  localparam int CTRL_NAND_LSB = 0;
  localparam int CTRL_SEL_LSB = 4;
  localparam int CTRL_WIDE_BIT = 6;
  localparam int CTRL_PSTART_LSB = 8;
  localparam int CTRL_MBSTART_BIT = 12;
  localparam int CTRL_LOCSTART_BIT = 13;

  // Status register fields
  localparam int STAT_STATE_LSB = 8;
  localparam int STAT_ERRNUM_LSB = 16;

  // Parity result fields
  localparam int PAR_ODD_LSB = 16;
  localparam int PAR_EVEN_LSB = 0;

  // Pair register fields
  localparam int PAIR_LO_LSB = 0;
  localparam int PAIR_HI_LSB = 16;

  // Correction state codes shown in the status register
  localparam logic [3:0] ECC_NO_ERR = 4'h0;
  localparam logic [3:0] ECC_DONE = 4'h3;
  localparam logic [3:0] ECC_CALC_NUM = 4'h5;
  localparam logic [3:0] ECC_PREP = 4'h6;
  localparam logic [3:0] ECC_SEARCH = 4'h7;
  localparam logic [3:0] ECC_CALC_VAL = 4'hC;

  // Reset value of every register
  localparam logic [31:0] RESET_VALUE = 32'h0000_0000;

  // Error locate sequencer
  typedef enum logic [2:0] {NFE_IDLE, NFE_COUNT, NFE_PREP, NFE_SEARCH, NFE_VALUE} nfe_fsm_t;

endpackage

/* File: verilog/nfe_ecc_regs.sv */
// NAND flash parity, check value, error location and error value registers on APB
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none

module nfe_ecc_regs #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Flash data words seen by the memory interface
  input wire logic data_valid,
  input wire logic [1:0] data_cs,
  input wire logic [15:0] data_word
);

  // All state of the block
  typedef struct packed {
    logic [3:0] nand_en;          // Chip select carries NAND flash
    logic [1:0] mb_sel;           // Chip select for multi-bit check
    logic wide;                   // 16-bit flash when set
    logic [3:0] par_start;        // Single-bit parity start per select
    logic mb_start;               // Multi-bit check start
    logic loc_start;              // Error locate start
    logic [3:0][11:0] odd;        // Odd parities per select
    logic [3:0][11:0] even;       // Even parities per select
    logic [3:0][8:0] widx;        // Word index per select
    logic [7:0][9:0] chk;         // Check or syndrome values
    logic [9:0] load;             // Last loaded check value
    logic [2:0] load_ptr;         // Next syndrome slot to load
    logic [3:0][9:0] loc;         // Error locations
    logic [3:0][9:0] val;         // Error values
    logic [1:0] errnum;           // Error count minus one
    logic [3:0] ecc_state;        // Correction state code
    nfe_pkg::nfe_fsm_t fsm;       // Locate sequencer state
    logic [1:0] step;             // Entry being produced
    logic [31:0] prdata;          // Read data
    logic pready;                 // Transfer ready
    logic pslverr;                // Unmapped address
  } nfe_state_t;

  // Registered state
  nfe_state_t q;
  // Next state, worked out each cycle
  nfe_state_t d;

  // Fold one flash word into a select's odd and even parities
  function automatic logic [23:0] nfe_par_upd(
    input logic [23:0] p,
    input logic [15:0] w,
    input logic [8:0] idx,
    input logic wide
  );
    logic [11:0] a;
    logic [23:0] r;
    r = p;
    for (int b = 0; b < 16; b++)
    begin
      // Upper byte lanes only exist on 16-bit flash
      if (wide || b < 8)
      begin
        // Low address bits pick the column, the word index picks the row
        if (wide)
          a = {idx[7:0], 4'(b)};
        else
          a = {idx, 3'(b)};
        for (int k = 0; k < 12; k++)
        begin
          // Odd parity covers addresses with bit k set, even the rest
          if (a[k])
            r[12+k] = r[12+k] ^ w[b];
          else
            r[k] = r[k] ^ w[b];
        end
      end
    end
    return r;
  endfunction

  // Place two 10-bit values in a pair register
  function automatic logic [31:0] nfe_pair(input logic [9:0] lo, input logic [9:0] hi);
    logic [31:0] r;
    r = nfe_pkg::RESET_VALUE;
    r[nfe_pkg::PAIR_LO_LSB +: 10] = lo;
    r[nfe_pkg::PAIR_HI_LSB +: 10] = hi;
    return r;
  endfunction

  // Address and register decode helpers
  logic setup;
  logic access;
  logic [7:0] ofs;
  logic [1:0] ridx;
  logic [31:0] rdata;
  logic hit;

  // Next-state logic
  always_comb
  begin
    // Scratch values for the parity fold, error count and pair index
    logic [23:0] pv;
    logic [2:0] cnt;
    logic [2:0] ci;
    pv = '0;
    cnt = '0;
    ci = '0;
    // Every field except pready and pslverr holds unless a branch below changes it
    d = q;
    d.pready = 1'b0;
    d.pslverr = 1'b0;
    // Bus phases; a transfer completes in the cycle its answer stands
    setup = psel && !penable;
    access = psel && penable && q.pready;
    // Upper address bits are ignored, so the map repeats
    ofs = paddr[7:0];
    ridx = 2'((ofs - nfe_pkg::OFS_PAR1) >> 2);
    rdata = nfe_pkg::RESET_VALUE;
    hit = 1'b1;

    // Read decode
    if (ofs == nfe_pkg::OFS_CTRL)
    begin
      rdata[nfe_pkg::CTRL_NAND_LSB +: 4] = q.nand_en;
      rdata[nfe_pkg::CTRL_SEL_LSB +: 2] = q.mb_sel;
      rdata[nfe_pkg::CTRL_WIDE_BIT] = q.wide;
      rdata[nfe_pkg::CTRL_PSTART_LSB +: 4] = q.par_start;
      rdata[nfe_pkg::CTRL_MBSTART_BIT] = q.mb_start;
      rdata[nfe_pkg::CTRL_LOCSTART_BIT] = q.loc_start;
    end
    else if (ofs == nfe_pkg::OFS_STAT)
    begin
      // Correction state and error count
      rdata[nfe_pkg::STAT_STATE_LSB +: 4] = q.ecc_state;
      rdata[nfe_pkg::STAT_ERRNUM_LSB +: 2] = q.errnum;
    end
    else if (ofs >= nfe_pkg::OFS_PAR1 && ofs <= nfe_pkg::OFS_PAR4 && ofs[1:0] == 2'b00)
    begin
      // Odd parities high, even parities low
      rdata[nfe_pkg::PAR_ODD_LSB +: 12] = q.odd[ridx];
      rdata[nfe_pkg::PAR_EVEN_LSB +: 12] = q.even[ridx];
    end
    else if (ofs == nfe_pkg::OFS_LOAD)
      rdata[9:0] = q.load;
    else if (ofs >= nfe_pkg::OFS_CHK1 && ofs <= nfe_pkg::OFS_CHK4 && ofs[1:0] == 2'b00)
    begin
      // Value 2n+1 low, value 2n+2 high
      ci = 3'((ofs - nfe_pkg::OFS_CHK1) >> 1);
      rdata = nfe_pair(q.chk[ci], q.chk[ci + 3'd1]);
    end
    else if (ofs == nfe_pkg::OFS_LOC1)
      rdata = nfe_pair(q.loc[0], q.loc[1]);
    else if (ofs == nfe_pkg::OFS_LOC2)
      rdata = nfe_pair(q.loc[2], q.loc[3]);
    else if (ofs == nfe_pkg::OFS_VAL1)
      rdata = nfe_pair(q.val[0], q.val[1]);
    else if (ofs == nfe_pkg::OFS_VAL2)
      rdata = nfe_pair(q.val[2], q.val[3]);
    else
      hit = 1'b0;

    // Setup cycle: prepare the answer for the access phase
    if (setup)
    begin
      d.pready = 1'b1;
      d.pslverr = !hit;
      d.prdata = (pwrite || !hit) ? nfe_pkg::RESET_VALUE : rdata;
    end

    // Flash data path
    for (int c = 0; c < 4; c++)
    begin
      // Word index restarts whenever a select is not accumulating
      if (!q.par_start[c])
        d.widx[c] = '0;
    end
    if (data_valid && q.nand_en[data_cs])
    begin
      // Single-bit parity over every word while started
      if (q.par_start[data_cs])
      begin
        pv = nfe_par_upd({q.odd[data_cs], q.even[data_cs]}, data_word,
          q.widx[data_cs], q.wide);
        d.odd[data_cs] = pv[23:12];
        d.even[data_cs] = pv[11:0];
        d.widx[data_cs] = q.widx[data_cs] + 9'd1;
      end
      // Multi-bit check values on the selected select
      if (q.mb_start && data_cs == q.mb_sel)
      begin
        for (int i = 0; i < 8; i++)
        begin
          d.chk[i] = {q.chk[i][8:0], q.chk[i][9]} ^ data_word[9:0] ^ 10'(i);
        end
      end
    end

    // Error locate sequencer
    unique case (q.fsm)
      nfe_pkg::NFE_IDLE:
      begin
        // Waiting for software to start
      end
      nfe_pkg::NFE_COUNT:
      begin
        // Count syndrome pairs that show an error
        for (int i = 0; i < 4; i++)
        begin
          if (q.chk[2*i] != '0 || q.chk[2*i+1] != '0)
            cnt = cnt + 3'd1;
        end
        if (cnt == '0)
        begin
          d.ecc_state = nfe_pkg::ECC_NO_ERR;
          d.errnum = '0;
          d.fsm = nfe_pkg::NFE_IDLE;
        end
        else
        begin
          d.errnum = 2'(cnt - 3'd1);
          d.ecc_state = nfe_pkg::ECC_PREP;
          d.fsm = nfe_pkg::NFE_PREP;
        end
      end
      nfe_pkg::NFE_PREP:
      begin
        // Begin the location search
        d.step = '0;
        d.ecc_state = nfe_pkg::ECC_SEARCH;
        d.fsm = nfe_pkg::NFE_SEARCH;
      end
      nfe_pkg::NFE_SEARCH:
      begin
        // Entries beyond the error count read as zero
        d.loc[q.step] = (q.step <= q.errnum) ? q.chk[{q.step, 1'b0}] : '0;
        d.step = q.step + 2'd1;
        if (q.step == 2'd3)
        begin
          d.ecc_state = nfe_pkg::ECC_CALC_VAL;
          d.fsm = nfe_pkg::NFE_VALUE;
        end
      end
      nfe_pkg::NFE_VALUE:
      begin
        // Produce the correction value for each location
        d.val[q.step] = (q.step <= q.errnum) ? q.chk[{q.step, 1'b1}] : '0;
        d.step = q.step + 2'd1;
        if (q.step == 2'd3)
        begin
          d.ecc_state = nfe_pkg::ECC_DONE;
          d.fsm = nfe_pkg::NFE_IDLE;
        end
      end
    endcase

    // Completed write
    if (access && pwrite)
    begin
      if (ofs == nfe_pkg::OFS_CTRL)
      begin
        // Every write replaces the whole control word
        d.nand_en = pwdata[nfe_pkg::CTRL_NAND_LSB +: 4];
        d.mb_sel = pwdata[nfe_pkg::CTRL_SEL_LSB +: 2];
        d.wide = pwdata[nfe_pkg::CTRL_WIDE_BIT];
        d.par_start = pwdata[nfe_pkg::CTRL_PSTART_LSB +: 4];
        d.mb_start = pwdata[nfe_pkg::CTRL_MBSTART_BIT];
        d.loc_start = pwdata[nfe_pkg::CTRL_LOCSTART_BIT];
        // Starting the locate run restarts the sequencer
        if (pwdata[nfe_pkg::CTRL_LOCSTART_BIT])
        begin
          d.step = '0;
          d.ecc_state = nfe_pkg::ECC_CALC_NUM;
          d.fsm = nfe_pkg::NFE_COUNT;
        end
      end
      else if (ofs == nfe_pkg::OFS_LOAD)
      begin
        // Loaded value is folded into the next syndrome slot
        d.load = pwdata[9:0];
        d.chk[q.load_ptr] = q.chk[q.load_ptr] ^ pwdata[9:0];
        d.load_ptr = q.load_ptr + 3'd1;
      end
      else if (ofs >= nfe_pkg::OFS_CHK1 && ofs <= nfe_pkg::OFS_CHK4 && ofs[1:0] == 2'b00)
      begin
        ci = 3'((ofs - nfe_pkg::OFS_CHK1) >> 1);
        // A fresh check pair restarts the load sequence
        d.chk[ci] = pwdata[nfe_pkg::PAIR_LO_LSB +: 10];
        d.chk[ci + 3'd1] = pwdata[nfe_pkg::PAIR_HI_LSB +: 10];
        d.load_ptr = '0;
      end
      else if (ofs == nfe_pkg::OFS_LOC1 || ofs == nfe_pkg::OFS_LOC2)
      begin
        // Offset bit 2 tells the first pair from the second
        d.loc[{ofs[2] ^ 1'b1, 1'b0}] = pwdata[nfe_pkg::PAIR_LO_LSB +: 10];
        d.loc[{ofs[2] ^ 1'b1, 1'b1}] = pwdata[nfe_pkg::PAIR_HI_LSB +: 10];
      end
      else if (ofs == nfe_pkg::OFS_VAL1 || ofs == nfe_pkg::OFS_VAL2)
      begin
        // Same pair selection as the locations
        d.val[{ofs[2] ^ 1'b1, 1'b0}] = pwdata[nfe_pkg::PAIR_LO_LSB +: 10];
        d.val[{ofs[2] ^ 1'b1, 1'b1}] = pwdata[nfe_pkg::PAIR_HI_LSB +: 10];
      end
    end

    // Completed read: side effects
    if (access && !pwrite)
    begin
      // Reading a result ends the run it belongs to
      if (ofs >= nfe_pkg::OFS_PAR1 && ofs <= nfe_pkg::OFS_PAR4 && ofs[1:0] == 2'b00)
        d.par_start[ridx] = 1'b0;
      else if (ofs >= nfe_pkg::OFS_CHK1 && ofs <= nfe_pkg::OFS_CHK4 && ofs[1:0] == 2'b00)
        d.mb_start = 1'b0;
      else if (ofs >= nfe_pkg::OFS_LOC1 && ofs <= nfe_pkg::OFS_VAL2 && ofs[1:0] == 2'b00)
        d.loc_start = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk)
  begin
    // Synchronous reset clears every register
    if (srst)
      q <= '0;
    else
      q <= d;
  end

  // Outputs straight from flip-flops
  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;

endmodule

`default_nettype wire

/* File: dv/nfe_ecc_monitor.sv */
// Concurrent checks on the APB side of the flash check-value registers
`timescale 1ns/1ps
`default_nettype none
module nfe_ecc_monitor #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic rd_ok; // Completed read in this cycle
  assign rd_ok = pready && !pwrite;
  // Answer comes in the first access cycle
  property p_ready_next;
    psel && !penable |=> pready;
  endproperty
  a_ready_next: assert property (p_ready_next) else $error("no answer after setup");
  // Answer lasts one cycle
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("answer held too long");
  // Answer only inside an access phase
  property p_ready_qual;
    pready |-> psel && penable;
  endproperty
  a_ready_qual: assert property (p_ready_qual) else $error("answer without access");
  // Offsets past the map are refused with zero data
  property p_unmapped;
    pready && paddr > nfe_pkg::OFS_VAL2 |-> pslverr && prdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  // Parity result keeps its reserved nibbles clear
  property p_par_rsv;
    rd_ok && paddr >= nfe_pkg::OFS_PAR1 && paddr <= nfe_pkg::OFS_PAR4
      |-> (prdata & 32'hF000_F000) == 32'h0;
  endproperty
  a_par_rsv: assert property (p_par_rsv) else $error("parity reserved bits set");
  // Pair registers carry only two 10-bit fields
  property p_pair_rsv;
    rd_ok && paddr >= nfe_pkg::OFS_CHK1 && paddr <= nfe_pkg::OFS_VAL2
      |-> (prdata & 32'hFC00_FC00) == 32'h0;
  endproperty
  a_pair_rsv: assert property (p_pair_rsv) else $error("pair reserved bits set");
  // Load register is ten bits wide
  property p_load_rsv;
    rd_ok && paddr == nfe_pkg::OFS_LOAD |-> prdata[31:10] == 22'h0;
  endproperty
  a_load_rsv: assert property (p_load_rsv) else $error("load reserved bits set");
  // Error count field is two bits
  property p_stat_rsv;
    rd_ok && paddr == nfe_pkg::OFS_STAT |-> prdata[31:18] == 14'h0;
  endproperty
  a_stat_rsv: assert property (p_stat_rsv) else $error("status reserved bits set");
  // Read data only changes together with an answer
  property p_idle_data;
    !pready |-> $stable(prdata);
  endproperty
  a_idle_data: assert property (p_idle_data) else $error("read data moved outside answer");
  // Main scenarios reached
  c_par: cover property (rd_ok && paddr == nfe_pkg::OFS_PAR1);
  c_err: cover property (pready && pslverr);
  c_loc: cover property (rd_ok && paddr == nfe_pkg::OFS_LOC2);
endmodule
bind nfe_ecc_regs nfe_ecc_monitor #(.ADDR_W(ADDR_W)) mon (.clk(clk), .srst(srst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr));
`default_nettype wire

/* File: dv/nfe_flash_model.sv */
// Flash device stand-in that streams random data words to the parity logic
`timescale 1ns/1ps
`default_nettype none
module nfe_flash_model (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Burst request
  input wire logic start,
  input wire logic [1:0] cs,
  input wire logic [4:0] len,
  output logic busy,
  // Data word strobe
  output logic data_valid,
  output logic [1:0] data_cs,
  output logic [15:0] data_word
);
  logic [4:0] left_q; // Words still to send
  logic [1:0] gap_q; // Idle cycles before next word
  int seed = 3; // Own random stream
  assign busy = left_q != 5'h0;
  // Random gaps give prompt and slow words; junk on the bus between words
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      left_q <= 5'h0;
      gap_q <= 2'h0;
      data_valid <= 1'b0;
      data_cs <= 2'h0;
      data_word <= 16'h0000;
    end
    else if (start)
      left_q <= len;
    else if (busy && gap_q == 2'h0)
    begin
      left_q <= left_q - 5'h1;
      gap_q <= 2'($random(seed));
      data_valid <= 1'b1;
      data_cs <= cs;
      data_word <= 16'($random(seed));
    end
    else
    begin
      gap_q <= gap_q - 2'(gap_q != 2'h0);
      data_valid <= 1'b0;
      data_cs <= ~data_cs;
      data_word <= ~data_word;
    end
  end
endmodule
`default_nettype wire

/* File: dv/tb_top.sv */
// Self-checking bench for the flash check-value register block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, start = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r, d, ctl, xp;
  logic [1:0] fcs = 2'h0, data_cs;
  logic [4:0] flen = 5'h0;
  logic pready, pslverr, data_valid, busy, e, wide;
  logic [15:0] data_word;
  logic [23:0] exp_par; // Expected odd and even parity
  logic [31:0] v [4]; // Check pairs fed to the locate run
  int seed = 3, fails = 0, check_count = 0, widx;
  always #25 clk = ~clk;
  nfe_ecc_regs uut (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .data_valid(data_valid), .data_cs(data_cs), .data_word(data_word));
  nfe_flash_model flash (.clk(clk), .srst(srst), .start(start), .cs(fcs), .len(flen),
    .busy(busy), .data_valid(data_valid), .data_cs(data_cs), .data_word(data_word));
  // Folds one word into the parity; each set bit flips odd or even per address bit
  function automatic logic [23:0] par_step(logic [23:0] p, logic [15:0] w, int i, logic wd);
    logic [11:0] a;
    for (int b = 0; b < 16; b++)
    begin
      a = wd ? 12'(i * 16 + b) : 12'(i * 8 + b);
      if (w[b] && (wd || b < 8))
        p = p ^ {a, ~a};
    end
    return p;
  endfunction
  // Mirrors every word the flash hands over
  always @(posedge clk)
    if (data_valid === 1'b1)
    begin
      exp_par <= par_step(exp_par, data_word, widx, wide);
      widx <= widx + 1;
    end
  task automatic chk(string n, logic [31:0] x, logic [31:0] g);
    check_count++;
    if (g !== x)
    begin
      fails++;
      $display("unexpected %s: expected %h seen %h", n, x, g);
    end
  endtask
  // One APB transfer, held until pready
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] dw);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= dw;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), x, r);
  endtask
  // Starts a flash burst and waits for its end
  task automatic burst(logic [1:0] c, logic [4:0] l);
    @(posedge clk);
    fcs <= c;
    flen <= l;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    do
    begin
      @(posedge clk);
    end
    while (busy !== 1'b0);
    // Let the last word reach the design and the parity mirror
    @(posedge clk);
  endtask
  task wrap_up;
    if (fails == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 15; i++)
      rd(8'(i * 4), 32'h0);
    apb(1'b0, 8'h3C, 32'h0);
    chk("pslverr", 32'h1, {31'h0, e});
    apb(1'b1, nfe_pkg::OFS_PAR1, 32'hFFFF_FFFF);
    rd(nfe_pkg::OFS_PAR1, 32'h0);
    for (int a = 28; a <= 56; a += 4)
    begin
      d = $random(seed);
      apb(1'b1, 8'(a), d);
      rd(8'(a), d & 32'h03FF_03FF);
    end
    ctl = $random(seed);
    apb(1'b1, nfe_pkg::OFS_CHK1, 32'h0);
    apb(1'b1, nfe_pkg::OFS_LOAD, d);
    apb(1'b1, nfe_pkg::OFS_LOAD, ctl);
    rd(nfe_pkg::OFS_CHK1, {6'h0, ctl[9:0], 6'h0, d[9:0]});
    // Parity on a random select, byte then word wide
    for (int w = 0; w < 2; w++)
    begin
      d = $random(seed);
      wide = 1'(w);
      ctl = (32'h1 << d[1:0]) | (32'(w) << 6) | (32'h100 << d[1:0]);
      apb(1'b1, nfe_pkg::OFS_CTRL, ctl);
      exp_par = 24'h0;
      widx = 0;
      burst(d[1:0], 5'h9 + 5'(w));
      xp = {4'h0, exp_par[23:12], 4'h0, exp_par[11:0]};
      rd(nfe_pkg::OFS_PAR1 + 8'(d[1:0] * 4), xp);
      rd(nfe_pkg::OFS_CTRL, ctl & ~(32'h100 << d[1:0]));
    end
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, nfe_pkg::OFS_CTRL, 32'h0000_1000);
      apb(1'b0, nfe_pkg::OFS_CHK1 + 8'(i * 4), 32'h0);
      rd(nfe_pkg::OFS_CTRL, 32'h0);
    end
    // Locate runs with four errors down to none
    for (int n = 4; n >= 0; n--)
    begin
      for (int k = 0; k < 4; k++)
      begin
        v[k] = k < n ? ($random(seed) | 32'h1) & 32'h03FF_03FF : 32'h0;
        apb(1'b1, nfe_pkg::OFS_CHK1 + 8'(k * 4), v[k]);
      end
      apb(1'b1, nfe_pkg::OFS_CTRL, 32'h0000_2000);
      repeat (12) @(posedge clk);
      xp = {14'h0, 2'(n > 0 ? n - 1 : 0), 4'h0,
        (n > 0 ? nfe_pkg::ECC_DONE : nfe_pkg::ECC_NO_ERR), 8'h00};
      rd(nfe_pkg::OFS_STAT, xp);
      for (int j = 0; j < 2 && n > 0; j++)
      begin
        rd(nfe_pkg::OFS_LOC1 + 8'(j * 4), {6'h0, v[2*j+1][9:0], 6'h0, v[2*j][9:0]});
        rd(nfe_pkg::OFS_VAL1 + 8'(j * 4), {6'h0, v[2*j+1][25:16], 6'h0, v[2*j][25:16]});
      end
      // With no errors nothing reads the results, so the start stays set
      rd(nfe_pkg::OFS_CTRL, n > 0 ? 32'h0 : 32'h0000_2000);
    end
    wrap_up;
  end
  // Cuts a hung run short
  initial
  begin
    repeat (4000) @(posedge clk);
    fails++;
    wrap_up;
  end
endmodule
`default_nettype wire
